// ==== wake_pkg.sv ====
// package: register map, field positions, reset values and timing constants
`default_nettype none
package wake_pkg;
    // register byte addresses
    localparam logic [7:0] PM_CTRL_ADDR = 8'h84;
    localparam logic [7:0] HARDWARE_CONFIG_REG_ADDR = 8'h74;
    localparam logic [7:0] BYTE_TEST_ADDR = 8'h64;
    localparam logic [7:0] EVENT_SRC_ADDR = 8'hA0;
    // field positions in the power-management control register
    localparam int READY_BIT = 0;
    localparam int PIN_EN_BIT = 1;
    localparam int PIN_POL_BIT = 2;
    localparam int PULSE_SEL_BIT = 3;
    localparam int CAUSE_LO = 4;
    localparam int DRIVE_TYPE_BIT = 6;
    localparam int ENERGY_EN_BIT = 8;
    localparam int FRAME_EN_BIT = 9;
    localparam int MODE_LO = 12;
    // wake-cause codes
    localparam logic [1:0] CAUSE_NONE = 2'h0;
    localparam logic [1:0] CAUSE_ENERGY = 2'h1;
    localparam logic [1:0] CAUSE_FRAME = 2'h2;
    localparam logic [1:0] CAUSE_MULTI = 2'h3;
    // power-state codes
    localparam logic [1:0] MODE_FULL = 2'h0;
    localparam logic [1:0] MODE_FRAME = 2'h1;
    localparam logic [1:0] MODE_ENERGY = 2'h2;
    // reset values
    localparam logic [1:0] CAUSE_RESET = 2'h0;
    localparam logic [31:0] HARDWARE_CONFIG_REG_RESET = 32'h0000_0000;
    // timing
    localparam int CLK_MHZ = 250;
    localparam int PULSE_MS = 50;
    localparam int PULSE_CYCLES = PULSE_MS * 1000 * CLK_MHZ;
    localparam int SETTLE_NS = 1000;
    localparam int SETTLE_CYCLES = SETTLE_NS * CLK_MHZ / 1000;
endpackage
`default_nettype wire

// ==== wake_pulse_timer.sv ====
// pulse timer: holds its output for a fixed count after a start strobe
`default_nettype none
module wake_pulse_timer
    import wake_pkg::*;
#(
    parameter int unsigned COUNT = PULSE_CYCLES
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // control
    input wire logic start,
    input wire logic cancel,
    // state
    output logic busy
);
    typedef struct packed {
        logic [31:0] cnt;
        logic busy;
    } st_s;
    st_s st_r, st_nxt;

    always_comb begin
        st_nxt = st_r;
        if (cancel) begin
            st_nxt.busy = 1'b0;
            st_nxt.cnt = 32'h0000_0000;
        end else if (start) begin
            st_nxt.busy = 1'b1;
            st_nxt.cnt = 32'(COUNT - 1);
        end else if (st_r.busy) begin
            if (st_r.cnt == 32'h0000_0000) begin
                st_nxt.busy = 1'b0;
            end else begin
                st_nxt.cnt = st_r.cnt - 32'h0000_0001;
            end
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign busy = st_r.busy;
endmodule
`default_nettype wire

// ==== ready_settle.sv ====
// ready tracker: counts settle time after leaving a reduced-power state
`default_nettype none
module ready_settle
    import wake_pkg::*;
#(
    parameter int unsigned SETTLE = SETTLE_CYCLES
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // power state
    input wire logic lowPower,
    // result
    output logic ready
);
    typedef struct packed {
        logic [31:0] cnt;
        logic ready;
    } st_s;
    st_s st_r, st_nxt;

    always_comb begin
        st_nxt = st_r;
        if (lowPower) begin
            st_nxt.ready = 1'b0;
            st_nxt.cnt = 32'(SETTLE);
        end else if (st_r.cnt != 32'h0000_0000) begin
            st_nxt.cnt = st_r.cnt - 32'h0000_0001;
        end else begin
            st_nxt.ready = 1'b1;
        end
    end

    // reset starts a full settle interval, ready low
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            st_r <= '{cnt: 32'(SETTLE), ready: 1'b0};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign ready = st_r.ready;
endmodule
`default_nettype wire

// ==== wake_event_indicator.sv ====
// wake-event indicator: wake cause, wake pin, ready flag, AHB-Lite slave
// What this block does
// - wake cause field reports none, energy, frame, or multiple events.
// - writing one to a cause bit clears it; zero leaves it.
// - cause clears only act in full power with ready set.
// - a cause bit stays set while any source feeding it is set.
// - pulse mode drives the wake pin active for 50 ms per event.
// - static mode holds the wake pin active after an event.
// - clearing cause bits or the enable deactivates the wake pin.
// - polarity bit: set means active high, clear means active low.
// - open-drain drive ignores polarity and is always active low.
// - pin enable clear keeps the wake pin inactive.
// - pin enable does not affect the internal wake interrupt.
// - read-only ready flag, readable in every power mode.
// - cause, pulse select, polarity and pin enable reset to zero.
// - power-state field selects full, frame detect or energy detect.
// - any write to the byte-order test register wakes the device.
// - frame wake enabled: frame events drive pin and interrupt.
// - energy wake enabled: energy events drive pin and interrupt.
`default_nettype none
module wake_event_indicator
    import wake_pkg::*;
#(
    parameter int unsigned PULSE_LEN = PULSE_CYCLES,
    parameter int unsigned SETTLE_LEN = SETTLE_CYCLES
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // wake event sources, level, held until cleared by their owner
    input wire logic energyEvent,
    input wire logic frameEvent,
    // wake pin, open-drain or push-pull
    output logic wakeEventPinOut,
    output logic wakeEventPinOe,
    // internal wake interrupt and power state
    output logic wakeEventInterrupt,
    output logic [1:0] powerStateSelect
);
    typedef struct packed {
        logic [1:0] wakeCause;
        logic pulseSel;
        logic pinPol;
        logic pinEn;
        logic driveType;
        logic energyWakeEn;
        logic frameWakeEn;
        logic [1:0] powerState;
        logic [31:0] hwConfig;
        logic [1:0] srcClr;
        logic wActive;
        logic [7:0] wAddr;
        logic rValid;
        logic [31:0] rData;
        logic pinAsserted;
        logic pinOut;
        logic pinOe;
        logic irq;
        logic [1:0] evPrev;
    } st_s;
    st_s st_r, st_nxt;

    logic ready;
    logic pulseBusy;
    logic pulseStart;
    logic pinCancel;
    logic [1:0] evLive;

    ////////////////////////////////////////////////////////////////////////
    // helpers

    // ready only counts once the power state is back to full
    function automatic logic [31:0] pmWord(input st_s s, input logic rdy);
        logic [31:0] w;
        w = 32'h0000_0000;
        w[READY_BIT] = rdy & (s.powerState == MODE_FULL);
        w[PIN_EN_BIT] = s.pinEn;
        w[PIN_POL_BIT] = s.pinPol;
        w[PULSE_SEL_BIT] = s.pulseSel;
        w[CAUSE_LO +: 2] = s.wakeCause;
        w[DRIVE_TYPE_BIT] = s.driveType;
        w[ENERGY_EN_BIT] = s.energyWakeEn;
        w[FRAME_EN_BIT] = s.frameWakeEn;
        w[MODE_LO +: 2] = s.powerState;
        return w;
    endfunction

    // read mux; unmapped offsets read as zero
    function automatic logic [31:0] readWord(input st_s s, input logic rdy,
        input logic [7:0] a, input logic [1:0] src);
        logic [31:0] w;
        w = 32'h0000_0000;
        unique case (a)
            PM_CTRL_ADDR: begin
                w = pmWord(s, rdy);
            end
            HARDWARE_CONFIG_REG_ADDR: begin
                w = s.hwConfig;
            end
            EVENT_SRC_ADDR: begin
                w[1:0] = src;
            end
            default: begin
                w = 32'h0000_0000;
            end
        endcase
        return w;
    endfunction

    // data phase of a write: apply the word to the addressed register
    function automatic st_s applyWrite(input st_s s, input logic rdy,
        input logic [31:0] wd);
        st_s n;
        n = s;
        unique case (s.wAddr)
            PM_CTRL_ADDR: begin
                n.pinEn = wd[PIN_EN_BIT];
                n.pinPol = wd[PIN_POL_BIT];
                n.pulseSel = wd[PULSE_SEL_BIT];
                n.driveType = wd[DRIVE_TYPE_BIT];
                n.energyWakeEn = wd[ENERGY_EN_BIT];
                n.frameWakeEn = wd[FRAME_EN_BIT];
                // reserved code is ignored, state kept
                if (wd[MODE_LO +: 2] != 2'h3) begin
                    n.powerState = wd[MODE_LO +: 2];
                end
            end
            HARDWARE_CONFIG_REG_ADDR: begin
                // ignored until the block has settled
                if (rdy) begin
                    n.hwConfig = wd;
                end
            end
            EVENT_SRC_ADDR: begin
                if (rdy) begin
                    n.srcClr = wd[1:0];
                end
            end
            BYTE_TEST_ADDR: begin
                n.powerState = MODE_FULL;
            end
            default: begin
                n = s;
            end
        endcase
        return n;
    endfunction

    // pin value and enable, returned as {oe, out}
    function automatic logic [1:0] pinDrive(input logic act,
        input logic pushPull, input logic pol);
        logic [1:0] d;
        d = 2'b00;
        if (!pushPull) begin
            // open drain: pull low when active, release otherwise
            d[0] = 1'b0;
            d[1] = act;
        end else begin
            d[0] = act ^ ~pol;
            d[1] = 1'b1;
        end
        return d;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // sub-blocks

    ready_settle #(.SETTLE(SETTLE_LEN)) uSettle (
        .ref_clk(ref_clk),
        .reset(reset),
        .lowPower(st_r.powerState != MODE_FULL),
        .ready(ready)
    );

    wake_pulse_timer #(.COUNT(PULSE_LEN)) uPulse (
        .ref_clk(ref_clk),
        .reset(reset),
        .start(pulseStart),
        .cancel(pinCancel),
        .busy(pulseBusy)
    );

    ////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        logic addrPhase;
        logic [1:0] clr;
        logic [1:0] causeNxt;
        logic active;
        logic [31:0] wd;
        addrPhase = 1'b0;
        clr = 2'b00;
        causeNxt = 2'b00;
        active = 1'b0;
        wd = hwdata;
        st_nxt = st_r;
        st_nxt.rValid = 1'b0;
        st_nxt.wActive = 1'b0;
        st_nxt.srcClr = 2'b00;
        pulseStart = 1'b0;
        pinCancel = 1'b0;

        // qualified event sources
        evLive[0] = energyEvent & st_r.energyWakeEn;
        evLive[1] = frameEvent & st_r.frameWakeEn;

        // write data phase
        if (st_r.wActive) begin
            st_nxt = applyWrite(st_nxt, ready, wd);
            if (st_r.wAddr == PM_CTRL_ADDR && ready &&
                st_r.powerState == MODE_FULL) begin
                clr = wd[CAUSE_LO +: 2];
            end
        end

        // cause: sources set, set wins over clear, live source holds bit
        causeNxt = st_r.wakeCause & ~clr;
        causeNxt = causeNxt | evLive;
        st_nxt.wakeCause = causeNxt;

        // rising edge of a qualified source is a new wake event
        st_nxt.evPrev = evLive;
        if ((evLive & ~st_r.evPrev) != 2'b00) begin
            pulseStart = 1'b1;
        end

        // interrupt independent of pin enable
        st_nxt.irq = causeNxt != CAUSE_NONE;

        // pin state machine
        if (causeNxt == CAUSE_NONE || !st_nxt.pinEn ||
            (st_nxt.frameWakeEn | st_nxt.energyWakeEn) == 1'b0) begin
            pinCancel = 1'b1;
        end
        if (st_nxt.pulseSel) begin
            active = pulseBusy | pulseStart;
        end else begin
            active = causeNxt != CAUSE_NONE;
        end
        active = active & st_nxt.pinEn & ~pinCancel;
        st_nxt.pinAsserted = active;
        {st_nxt.pinOe, st_nxt.pinOut} =
            pinDrive(active, st_nxt.driveType, st_nxt.pinPol);

        // address phase: one-cycle zero-wait slave
        addrPhase = hsel & hready & htrans[1];
        if (addrPhase) begin
            if (hwrite) begin
                st_nxt.wActive = 1'b1;
                st_nxt.wAddr = haddr[7:0];
            end else begin
                st_nxt.rValid = 1'b1;
                st_nxt.rData = readWord(st_r, ready, haddr[7:0],
                    {energyEvent, frameEvent});
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // state register

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            st_r <= '0;
            st_r.hwConfig <= HARDWARE_CONFIG_REG_RESET;
        end else begin
            st_r <= st_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs

    assign hrdata = st_r.rData;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign wakeEventPinOut = st_r.pinOut;
    assign wakeEventPinOe = st_r.pinOe;
    assign wakeEventInterrupt = st_r.irq;
    assign powerStateSelect = st_r.powerState;
endmodule
`default_nettype wire

// ==== wake_event_indicator_asserts.sv ====
// checker: wake pin, interrupt, power state and bus response relations
`default_nettype none
module wake_event_indicator_asserts
    import wake_pkg::*;
#(
    parameter int unsigned PULSE_LEN = 20
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // bus
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    // wake side
    input wire logic energyEvent,
    input wire logic wakeEventPinOut,
    input wire logic wakeEventPinOe,
    input wire logic wakeEventInterrupt,
    input wire logic [1:0] powerStateSelect
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int P_LO = PULSE_LEN - 2;
    localparam int P_HI = PULSE_LEN + 2;
    logic [7:0] aQ_r;
    logic wQ_r;
    logic [31:0] ctl_r;
    logic [31:0] cnt_r;
    logic act;
    logic dWr;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);
    ////////////////////////////////////////////////////////////
    // shadow of the last control word; pin follows on the same edge
    assign dWr = wQ_r && hready;
    assign act = ctl_r[DRIVE_TYPE_BIT] ? wakeEventPinOe &&
        wakeEventPinOut == ctl_r[PIN_POL_BIT] : wakeEventPinOe;
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            wQ_r <= 1'b0;
            aQ_r <= 8'h00;
            ctl_r <= 32'h0000_0000;
            cnt_r <= 32'h0000_0000;
        end else begin
            if (hready) begin
                wQ_r <= hsel && htrans[1] && hwrite;
                aQ_r <= haddr[7:0];
            end
            if (dWr && aQ_r == PM_CTRL_ADDR) begin
                ctl_r <= hwdata;
            end
            cnt_r <= act ? cnt_r + 32'h0000_0001 : 32'h0000_0000;
        end
    end
    ////////////////////////////////////////////////////////////
    a_resp_okay: assert property (hreadyout && !hresp)
        else $error("bus answer not ready or not okay");
    a_reset_vals: assert property ($past(reset) |->
        !wakeEventInterrupt && !wakeEventPinOe && powerStateSelect == 2'h0)
        else $error("outputs not idle after reset");
    a_od_low: assert property (
        !ctl_r[DRIVE_TYPE_BIT] && $stable(ctl_r) |-> !wakeEventPinOut)
        else $error("open-drain pin driven high");
    a_pin_off: assert property (
        !ctl_r[PIN_EN_BIT] && $stable(ctl_r) |-> !act)
        else $error("disabled pin went active");
    a_static_hold: assert property (!ctl_r[PULSE_SEL_BIT] &&
        ctl_r[PIN_EN_BIT] && $stable(ctl_r) && $past(act) &&
        wakeEventInterrupt |-> act)
        else $error("static pin dropped with cause set");
    a_pulse_len: assert property ($fell(act) &&
        ctl_r[PULSE_SEL_BIT] && $stable(ctl_r) |->
        cnt_r >= P_LO && cnt_r <= P_HI)
        else $error("wake pulse length wrong");
    a_energy_irq: assert property (
        energyEvent && ctl_r[ENERGY_EN_BIT] |-> ##[0:4] wakeEventInterrupt)
        else $error("energy event raised no interrupt");
    a_mode_wake: assert property (dWr && aQ_r == BYTE_TEST_ADDR |->
        ##[1:3] powerStateSelect == MODE_FULL)
        else $error("byte test write did not wake");
    a_mode_legal: assert property (powerStateSelect != 2'h3)
        else $error("reserved power state shown");
    c_pulse: cover property ($rose(act) && ctl_r[PULSE_SEL_BIT]);
    c_wake: cover property (dWr && aQ_r == BYTE_TEST_ADDR);
    c_irq: cover property ($rose(wakeEventInterrupt));
endmodule
bind wake_event_indicator wake_event_indicator_asserts #(
    .PULSE_LEN(PULSE_LEN)
) wake_event_indicator_asserts_inst (
    .ref_clk(ref_clk), .reset(reset), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .energyEvent(energyEvent),
    .wakeEventPinOut(wakeEventPinOut), .wakeEventPinOe(wakeEventPinOe),
    .wakeEventInterrupt(wakeEventInterrupt),
    .powerStateSelect(powerStateSelect)
);
`default_nettype wire

// ==== wake_sink_model.sv ====
// power-controller model: sees the wake pin through a pull-up
`default_nettype none
module wake_sink_model (
    // pin as driven by the device
    input wire logic pinOut,
    input wire logic pinOe,
    // level seen by the power controller
    output logic pinLevel
);
    timeunit 1ns;
    timeprecision 1ps;
    // a released open-drain line floats up, never holds its last value
    assign pinLevel = pinOe ? pinOut : 1'b1;
endmodule
`default_nettype wire

// ==== tb.sv ====
// testbench: register access, wake pin modes and power states
`default_nettype none
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin \
    miscompares++; $display("MISMATCH %0t got %h exp %h", $time, a, e); \
    end end
module tb
    import wake_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int PL = 20;
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0000_0000;
    logic energyEvent = 1'b0;
    logic frameEvent = 1'b0;
    logic [31:0] hrdata;
    logic [31:0] rdv;
    logic hreadyout;
    logic pinOut;
    logic pinOe;
    logic pin;
    logic irq;
    logic [1:0] mode;
    int miscompares = 0;
    int total_checks = 0;
    wake_event_indicator #(.PULSE_LEN(PL), .SETTLE_LEN(4))
    wake_event_indicator_inst (
        .ref_clk(ref_clk), .reset(reset), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(), .energyEvent(energyEvent), .frameEvent(frameEvent),
        .wakeEventPinOut(pinOut), .wakeEventPinOe(pinOe),
        .wakeEventInterrupt(irq), .powerStateSelect(mode)
    );
    wake_sink_model wake_sink_model_inst (
        .pinOut(pinOut), .pinOe(pinOe), .pinLevel(pin)
    );
    initial begin
        forever #2 ref_clk = ~ref_clk;
    end
    ////////////////////////////////////////////////////////////
    task automatic summarize();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    task automatic waitRdy();
        int n;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (hreadyout !== 1'b1 && n < 50);
        if (n >= 50) begin
            miscompares++;
            summarize();
        end
    endtask
    // address phase, then data phase; read data taken at its end edge
    task automatic xfer(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= {24'h00_0000, a};
        hwrite <= w;
        htrans <= 2'h2;
        waitRdy();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        waitRdy();
        rdv = hrdata;
    endtask
    task automatic pollRdy();
        int n;
        n = 0;
        do begin
            xfer(1'b0, PM_CTRL_ADDR, 32'h0000_0000);
            n++;
        end while (rdv[READY_BIT] !== 1'b1 && n < 40);
        `CHK(rdv[READY_BIT], 1'b1)
        if (n >= 40) begin
            summarize();
        end
    endtask
    task automatic cause(input logic [1:0] e);
        xfer(1'b0, PM_CTRL_ADDR, 32'h0000_0000);
        `CHK(rdv[5:4], e)
    endtask
    ////////////////////////////////////////////////////////////
    initial begin
        repeat (20) @(posedge ref_clk);
        reset <= 1'b0;
        @(posedge ref_clk);
        xfer(1'b0, PM_CTRL_ADDR, 32'h0000_0000);
        `CHK(rdv[5:1], 5'h00)
        xfer(1'b0, HARDWARE_CONFIG_REG_ADDR, 32'h0000_0000);
        `CHK(rdv, HARDWARE_CONFIG_REG_RESET)
        pollRdy();
        xfer(1'b0, 8'h10, 32'h0000_0000);
        `CHK(rdv, 32'h0000_0000)
        // static push-pull, active high, both sources enabled
        xfer(1'b1, PM_CTRL_ADDR, 32'h0000_0346);
        energyEvent <= 1'b1;
        cyc(4);
        `CHK(pin, 1'b1)
        cause(CAUSE_ENERGY);
        frameEvent <= 1'b1;
        cyc(4);
        cause(CAUSE_MULTI);
        frameEvent <= 1'b0;
        xfer(1'b1, PM_CTRL_ADDR, 32'h0000_0366);
        cause(CAUSE_ENERGY);
        xfer(1'b1, PM_CTRL_ADDR, 32'h0000_0356);
        cause(CAUSE_ENERGY);
        energyEvent <= 1'b0;
        xfer(1'b1, PM_CTRL_ADDR, 32'h0000_0356);
        cause(CAUSE_NONE);
        cyc(2);
        `CHK(pin, 1'b0)
        // active low push-pull, then the pin enable is dropped
        xfer(1'b1, PM_CTRL_ADDR, 32'h0000_0242);
        cyc(2);
        `CHK(pin, 1'b1)
        frameEvent <= 1'b1;
        cyc(4);
        `CHK(pin, 1'b0)
        xfer(1'b1, PM_CTRL_ADDR, 32'h0000_0240);
        cyc(2);
        `CHK(pin, 1'b1)
        `CHK(irq, 1'b1)
        frameEvent <= 1'b0;
        xfer(1'b1, PM_CTRL_ADDR, 32'h0000_0260);
        // open-drain with polarity set still pulls low
        xfer(1'b1, PM_CTRL_ADDR, 32'h0000_0106);
        cyc(2);
        `CHK(pin, 1'b1)
        energyEvent <= 1'b1;
        cyc(4);
        `CHK(pin, 1'b0)
        energyEvent <= 1'b0;
        xfer(1'b1, PM_CTRL_ADDR, 32'h0000_0116);
        // pulse mode: pin ends while the cause is still set
        xfer(1'b1, PM_CTRL_ADDR, 32'h0000_014e);
        energyEvent <= 1'b1;
        cyc(4);
        `CHK(pin, 1'b1)
        cyc(PL + 2);
        `CHK(pin, 1'b0)
        energyEvent <= 1'b0;
        cause(CAUSE_ENERGY);
        for (int m = 1; m < 4; m++) begin
            xfer(1'b1, PM_CTRL_ADDR, 32'(m) << MODE_LO);
            xfer(1'b0, PM_CTRL_ADDR, 32'h0000_0000);
            `CHK(mode, (m == 3) ? MODE_FULL : 2'(m))
            `CHK(rdv[READY_BIT], m == 3)
            xfer(1'b1, BYTE_TEST_ADDR, 32'h0000_0000);
            pollRdy();
            `CHK(mode, MODE_FULL)
        end
        // a clear sent in reduced power is refused
        xfer(1'b1, PM_CTRL_ADDR, 32'h0000_2000);
        xfer(1'b1, PM_CTRL_ADDR, 32'h0000_2030);
        cause(CAUSE_ENERGY);
        xfer(1'b1, BYTE_TEST_ADDR, 32'h0000_0000);
        pollRdy();
        xfer(1'b1, PM_CTRL_ADDR, 32'h0000_0030);
        cause(CAUSE_NONE);
        summarize();
    end
endmodule
`default_nettype wire
